// ===== gpd_consts.vh
`ifndef GPD_CONSTS_VH
`define GPD_CONSTS_VH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define GPD_ADDR_W 8
`define GPD_OFS_LATCH 8'h00
`define GPD_OFS_SET 8'h04
`define GPD_OFS_CLEAR 8'h08
`define GPD_OFS_TOGGLE 8'h0C
`define GPD_OFS_INPUT 8'h10
`define GPD_OFS_DIR 8'h14

// ****************************************************************
// Reset values and data width.
// ****************************************************************
`define GPD_DATA_W 32
`define GPD_RST_LATCH 32'h00000000
`define GPD_RST_INPUT 32'h00000000
`define GPD_RST_DIR 32'h00000000
`define GPD_ZERO 32'h00000000

`endif

// ===== gpd_port.v
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "gpd_consts.vh"
// ****************************************************************
// General-purpose I/O port with latch, strobes, input and direction.
// ****************************************************************
module gpd_port #(
  parameter [`GPD_DATA_W-1:0] IMPL_MASK = 32'hFFFFFFFF
) (
  // Clock, enable and reset.
  input wire clk,
  input wire ce,
  input wire srst,
  // Register port.
  input wire [`GPD_ADDR_W-1:0] addr,
  input wire [`GPD_DATA_W-1:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [`GPD_DATA_W-1:0] rdata,
  output reg bus_err,
  // Pin mux status per pin.
  input wire [`GPD_DATA_W-1:0] pin_digital,
  input wire [`GPD_DATA_W-1:0] pin_ctrl_en,
  // Pins.
  input wire [`GPD_DATA_W-1:0] pin_in,
  output reg [`GPD_DATA_W-1:0] pin_out,
  output reg [`GPD_DATA_W-1:0] pin_oe
);
  // ****************************************************************
  // Register state.
  // ****************************************************************
  reg [`GPD_DATA_W-1:0] output_latch_q;
  reg [`GPD_DATA_W-1:0] pin_direction_q;
  reg [`GPD_DATA_W-1:0] pin_input_sample_q;

  // ****************************************************************
  // Next values and answers.
  // ****************************************************************
  reg [`GPD_DATA_W-1:0] output_latch_d;
  reg [`GPD_DATA_W-1:0] pin_direction_d;
  wire [`GPD_DATA_W-1:0] pin_input_sample_d;
  wire [`GPD_DATA_W-1:0] latch_after_toggle;
  reg [`GPD_DATA_W-1:0] rdata_d;
  reg err_d;

  // ****************************************************************
  // Address decode and strobe signals.
  // ****************************************************************
  reg hit;
  reg sel_latch;
  reg sel_set;
  reg sel_clear;
  reg sel_toggle;
  reg sel_input;
  reg sel_dir;
  reg wr_latch;
  reg wr_set;
  reg wr_clear;
  reg wr_toggle;
  reg wr_dir;
  reg access;
  reg [`GPD_DATA_W-1:0] set_mask;
  reg [`GPD_DATA_W-1:0] clear_mask;
  reg [`GPD_DATA_W-1:0] toggle_mask;
  wire [`GPD_DATA_W-1:0] pin_sync;
  genvar g;

  // ****************************************************************
  // Pin synchroniser.
  // ****************************************************************
  gpd_sync #(
    .W(`GPD_DATA_W)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  always @* begin
    sel_latch = 1'b0;
    sel_set = 1'b0;
    sel_clear = 1'b0;
    sel_toggle = 1'b0;
    sel_input = 1'b0;
    sel_dir = 1'b0;
    case (addr)
      `GPD_OFS_LATCH: begin
        sel_latch = 1'b1;
      end
      `GPD_OFS_SET: begin
        sel_set = 1'b1;
      end
      `GPD_OFS_CLEAR: begin
        sel_clear = 1'b1;
      end
      `GPD_OFS_TOGGLE: begin
        sel_toggle = 1'b1;
      end
      `GPD_OFS_INPUT: begin
        sel_input = 1'b1;
      end
      `GPD_OFS_DIR: begin
        sel_dir = 1'b1;
      end
      default: begin
        sel_latch = 1'b0;
      end
    endcase
    hit = sel_latch | sel_set | sel_clear | sel_toggle | sel_input | sel_dir;
  end

  // ****************************************************************
  // Access qualification.
  // ****************************************************************
  always @* begin
    access = wr_en | rd_en;
    wr_latch = wr_en & sel_latch;
    wr_set = wr_en & sel_set;
    wr_clear = wr_en & sel_clear;
    wr_toggle = wr_en & sel_toggle;
    wr_dir = wr_en & sel_dir;
  end

  // ****************************************************************
  // Write masks for the set, clear and toggle registers.
  // ****************************************************************
  always @* begin
    set_mask = `GPD_ZERO;
    if (wr_set) begin
      set_mask = wdata;
    end
  end

  always @* begin
    clear_mask = `GPD_ZERO;
    if (wr_clear) begin
      clear_mask = wdata;
    end
  end

  always @* begin
    toggle_mask = `GPD_ZERO;
    if (wr_toggle) begin
      toggle_mask = wdata;
    end
  end

  // ****************************************************************
  // Per-pin latch update and input sampling.
  // ****************************************************************
  generate
    for (g = 0; g < `GPD_DATA_W; g = g + 1) begin : g_pin
      wire set_bit;
      wire clear_bit;
      wire toggle_bit;
      wire live_bit;
      wire hold_bit;
      assign set_bit = output_latch_q[g] | set_mask[g];
      assign clear_bit = set_bit & ~clear_mask[g];
      assign toggle_bit = clear_bit ^ toggle_mask[g];
      assign latch_after_toggle[g] = toggle_bit;
      assign live_bit = pin_sync[g] & pin_digital[g];
      assign hold_bit = pin_ctrl_en[g] ? live_bit : pin_input_sample_q[g];
      assign pin_input_sample_d[g] = IMPL_MASK[g] & hold_bit;
    end
  endgenerate

  // ****************************************************************
  // Latch and direction next values.
  // ****************************************************************
  always @* begin
    output_latch_d = latch_after_toggle;
    if (wr_latch) begin
      output_latch_d = wdata;
    end
  end

  always @* begin
    pin_direction_d = pin_direction_q;
    if (wr_dir) begin
      pin_direction_d = wdata;
    end
  end

  // ****************************************************************
  // Read data.
  // ****************************************************************
  always @* begin
    rdata_d = `GPD_ZERO;
    if (rd_en) begin
      case (addr)
        `GPD_OFS_LATCH: begin
          rdata_d = output_latch_q;
        end
        `GPD_OFS_SET: begin
          rdata_d = `GPD_ZERO;
        end
        `GPD_OFS_CLEAR: begin
          rdata_d = `GPD_ZERO;
        end
        `GPD_OFS_TOGGLE: begin
          rdata_d = `GPD_ZERO;
        end
        `GPD_OFS_INPUT: begin
          rdata_d = pin_input_sample_q;
        end
        `GPD_OFS_DIR: begin
          rdata_d = pin_direction_q;
        end
        default: begin
          rdata_d = `GPD_ZERO;
        end
      endcase
    end
  end

  // ****************************************************************
  // Error answer.
  // ****************************************************************
  always @* begin
    err_d = 1'b0;
    if (access && !hit) begin
      err_d = 1'b1;
    end
  end

  // ****************************************************************
  // Output latch register.
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      output_latch_q <= `GPD_RST_LATCH;
    end else if (ce) begin
      output_latch_q <= output_latch_d;
    end
  end

  // ****************************************************************
  // Direction register.
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      pin_direction_q <= `GPD_RST_DIR;
    end else if (ce) begin
      pin_direction_q <= pin_direction_d;
    end
  end

  // ****************************************************************
  // Input sample register.
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      pin_input_sample_q <= `GPD_RST_INPUT;
    end else if (ce) begin
      pin_input_sample_q <= pin_input_sample_d;
    end
  end

  // ****************************************************************
  // Read data register.
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      rdata <= `GPD_ZERO;
    end else if (ce) begin
      rdata <= rdata_d;
    end
  end

  // ****************************************************************
  // Error register.
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      bus_err <= 1'b0;
    end else if (ce) begin
      bus_err <= err_d;
    end
  end

  // ****************************************************************
  // Pin level drivers.
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      pin_out <= `GPD_RST_LATCH;
    end else if (ce) begin
      pin_out <= output_latch_d;
    end
  end

  // ****************************************************************
  // Pin output enables.
  // ****************************************************************
  always @(posedge clk) begin
    if (srst) begin
      pin_oe <= `GPD_RST_DIR;
    end else if (ce) begin
      pin_oe <= pin_direction_d;
    end
  end
endmodule // gpd_port

// ===== gpd_port_sva.sv
`timescale 1ns/1ps
module gpd_port_chk #(parameter [31:0] IMPL_MASK = 32'hFFFFFFFF) (
  // Bus and pins.
  input wire clk,
  input wire srst,
  input wire ce,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] rdata,
  input wire bus_err,
  input wire [31:0] pin_digital,
  input wire [31:0] pin_out,
  input wire [31:0] pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire w = wr_en && ce;
  wire r = rd_en && ce;
  wire [31:0] o = pin_out;
  wire [31:0] d = wdata;
  wire s = addr == 8'h04 || addr == 8'h08 || addr == 8'h0C;
  wire m = s || addr == 8'h00 || addr == 8'h10 || addr == 8'h14;
  a_latch_write: assert property (w && addr == 8'h00 |=> o == $past(d))
    else $error("latch");
  a_set_bits: assert property (w && addr == 8'h04 |=> o == ($past(o) | $past(d)))
    else $error("set");
  a_clear_bits: assert property (w && addr == 8'h08 |=> o == ($past(o) & ~$past(d)))
    else $error("clear");
  a_toggle_bits: assert property (w && addr == 8'h0C |=> o == ($past(o) ^ $past(d)))
    else $error("toggle");
  a_dir_write: assert property (w && addr == 8'h14 |=> pin_oe == $past(d))
    else $error("dir");
  a_strobe_zero: assert property (r && s |=> rdata == 0)
    else $error("strobe");
  a_unmapped_err: assert property ((w || r) && !m |=> bus_err)
    else $error("err");
  a_input_mask: assert property (r && addr == 8'h10 |=> !(rdata & ~(pin_digital & IMPL_MASK)))
    else $error("input");
endmodule // gpd_port_chk
bind gpd_port gpd_port_chk #(.IMPL_MASK(IMPL_MASK)) u_chk (.*);

// ===== gpd_sync.v
`timescale 1ns/1ps
// ****************************************************************
// Two-stage synchroniser for a bus of pin levels.
// ****************************************************************
module gpd_sync #(
  parameter W = 32
) (
  // Clock, enable and reset.
  input wire clk,
  input wire srst,
  input wire ce,
  // Levels.
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (srst) begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // gpd_sync

// ===== gpio_port_data_direction_tb.sv
`timescale 1ns/1ps
module gpio_port_data_direction_tb;
  reg clk = 0, srst = 1, wr_en = 0, rd_en = 0, ce = 1;
  reg [7:0] addr = 0, i;
  reg [31:0] wdata = 0, pin_digital = 0, pin_ctrl_en = 0, pin_in = 0;
  wire [31:0] rdata, pin_out, pin_oe;
  wire bus_err;
  integer num_errors = 0, num_checks = 0;
  always #5 clk = ~clk;
  gpd_port #(.IMPL_MASK(32'h7FFFFFFF)) dut (.clk(clk), .ce(ce), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .bus_err(bus_err),
    .pin_digital(pin_digital), .pin_ctrl_en(pin_ctrl_en), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  task chk(input [32:0] s, input [32:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      wr_en <= 1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr_en <= 0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input b);
    begin
      @(posedge clk);
      rd_en <= 1;
      addr <= a;
      @(posedge clk);
      rd_en <= 0;
      #1;
      chk({bus_err, rdata}, {b, e});
    end
  endtask
  task end_of_test;
    begin
      if (num_errors == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #5000;
    num_errors = num_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 0;
    pin_ctrl_en <= 32'hFFFFFFFF;
    rd(8'h00, 0, 0);
    rd(8'h14, 0, 0);
    wr(8'h00, 32'hA5A50F0F);
    chk(pin_out, 32'hA5A50F0F);
    wr(8'h04, 32'h000000F0);
    chk(pin_out, 32'hA5A50FFF);
    wr(8'h08, 32'hA000000F);
    chk(pin_out, 32'h05A50FF0);
    wr(8'h0C, 32'hFFFF0000);
    chk(pin_out, 32'hFA5A0FF0);
    rd(8'h00, 32'hFA5A0FF0, 0);
    for (i = 4; i < 16; i = i + 4) rd(i, 0, 0);
    wr(8'h14, 32'h0F0F0F0F);
    chk(pin_oe, 32'h0F0F0F0F);
    @(posedge clk);
    pin_digital <= 32'hFFFF00FF;
    pin_in <= 32'h92345678;
    repeat (4) @(posedge clk);
    rd(8'h10, 32'h12340078, 0);
    @(posedge clk);
    pin_ctrl_en <= 0;
    pin_in <= 0;
    repeat (4) @(posedge clk);
    rd(8'h10, 32'h12340078, 0);
    @(posedge clk);
    pin_ctrl_en <= 32'hFFFFFFFF;
    repeat (4) @(posedge clk);
    rd(8'h10, 0, 0);
    rd(8'h18, 0, 1);
    wr(8'h40, 32'hFFFFFFFF);
    chk({bus_err, pin_out}, {1'b1, 32'hFA5A0FF0});
    @(posedge clk);
    ce <= 0;
    wr(8'h0C, 32'hFFFFFFFF);
    chk(pin_out, 32'hFA5A0FF0);
    @(posedge clk);
    ce <= 1;
    @(posedge clk);
    srst <= 1;
    @(posedge clk);
    srst <= 0;
    rd(8'h00, 0, 0);
    chk(pin_oe, 0);
    end_of_test;
  end
endmodule // gpio_port_data_direction_tb
